// file: shared/jltx_regs.vh
`ifndef JLTX_REGS_VH
`define JLTX_REGS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define JLTX_ADDR_PORT_CFG 12'h000
`define JLTX_ADDR_SYNC_CFG 12'h1dc
`define JLTX_ADDR_LINK_CFG 12'h100
`define JLTX_ADDR_STATUS 12'h104
// ****************************************
// Field positions
// ****************************************
`define JLTX_PORT_SOFT_RST_BIT 5
`define JLTX_SYNC_DIVRST_BIT 0
`define JLTX_LINK_SIMPLE_BIT 0
`define JLTX_LINK_TWO_LANE_BIT 1
`define JLTX_LINK_SCR_EN_BIT 2
`define JLTX_LINK_LANESYNC_BIT 3
`define JLTX_LINK_RES_LSB 4
`define JLTX_LINK_K_LSB 8
// ****************************************
// Reset values
// ****************************************
`define JLTX_LINK_CFG_RST 32'h0000_0d08
`define JLTX_SYNC_CFG_RST 32'h0000_0000
// ****************************************
// Control characters and timing
// ****************************************
`define JLTX_K28_5 8'hbc
`define JLTX_K28_0 8'h1c
`define JLTX_K28_3 8'h7c
`define JLTX_K28_4 8'h9c
`define JLTX_K28_7 8'hfc
`define JLTX_ILA_MF 2'h3
`define JLTX_CAL_TIME_NS 1000
`define JLTX_CLK_PERIOD_NS 50
`endif

// file: verilog/jltx_top.v
`timescale 1ns/100ps
// How it works
// R01: A configuration bit makes the sync pins a divider reset instead of SYNC~.
// R02: After reset the sync pins act as SYNC~.
// R03: Systems with divide 2 or 4 needing alignment must use divider reset.
// R04: Writing soft reset reruns the reset and calibration sequence.
// R05: The soft reset bit clears itself when calibration finishes.
// R06: Efficient and simple packing; efficient after reset.
// R07: Simple packing pads each sample to 16 bits; one frame per sample.
// R08: Efficient packing concatenates samples into whole octets, then slices.
// R09: Two-lane mode and reduced resolution are supported.
// R10: While SYNC~ is asserted, commas go out on every active lane.
// R11: The receiver asserts SYNC~ and releases it after code group sync.
// R12: On release, four multiframes of alignment sequence of K frames each.
// R13: With efficient packing, the second alignment multiframe carries the link parameters.
// R14: After the alignment sequence, packed sample data follows directly.
// R15: A frame's last octet repeating the previous one becomes a control character.
// R16: With lane sync, a repeated multiframe end uses another control character.
// R17: A bypassable self-synchronising scrambler 1+x^14+x^15.
// R18: The alignment sequence seeds the scrambler.
// R19: SYNC~ release is the timing event that restarts the frame pipeline.
// R20: One sync signal timed to the sample clock serves both functions.
// R21: Every lane octet is 8b/10b encoded.
// R22: Parameters at least one are held as value minus one.
// R23: The comma is K28.5 with correct running disparity.
`include "jltx_regs.vh"
module jltx_top
#(
   parameter CAL_CYCLES = (`JLTX_CAL_TIME_NS + `JLTX_CLK_PERIOD_NS - 1) / `JLTX_CLK_PERIOD_NS
)
(
   input wire i_clk,                 // Sample clock
   input wire i_rst_b,               // Synchronous reset, active low
   input wire [31:0] i_haddr,        // AHB address
   input wire [1:0] i_htrans,        // AHB transfer type
   input wire i_hwrite,              // AHB write
   input wire [2:0] i_hsize,         // AHB size
   input wire [31:0] i_hwdata,       // AHB write data
   input wire i_hsel,                // AHB select
   input wire i_hready,              // AHB bus ready
   output reg [31:0] o_hrdata,       // AHB read data
   output reg o_hreadyout,           // AHB slave ready
   output reg o_hresp,               // AHB response, always OKAY
   input wire i_sync_b,              // Sync pin pair, resolved, low = asserted
   input wire [13:0] i_samp_a,       // Converter 0 sample
   input wire [13:0] i_samp_b,       // Converter 1 sample
   output reg [29:0] o_lane_sym,     // Three 10-bit encoded symbols, lane 0 low
   output reg [2:0] o_lane_en,       // Active lanes
   output reg o_div_rst,             // Sample clock divider reset pulse
   output reg o_cal_busy             // Calibration running
);
   localparam ST_CGS = 2'h0;
   localparam ST_ILA = 2'h1;
   localparam ST_DATA = 2'h2;
   // ****************************************
   // 8b/10b encoder, one symbol with disparity
   // ****************************************
   function [10:0] enc8b10b; // {rd_out, sym[9:0]}, sym abcdei fghj
      input [7:0] d;
      input k;
      input rd;
      reg [5:0] s6;
      reg [3:0] s4;
      reg r1;
      reg alt;
      begin
         s6 = 6'h00;
         s4 = 4'h0;
         r1 = rd;
         alt = 1'b0;
         case (d[4:0])
            5'd0: s6 = 6'b100111; 5'd1: s6 = 6'b011101; 5'd2: s6 = 6'b101101; 5'd3: s6 = 6'b110001;
            5'd4: s6 = 6'b110101; 5'd5: s6 = 6'b101001; 5'd6: s6 = 6'b011001; 5'd7: s6 = 6'b111000;
            5'd8: s6 = 6'b111001; 5'd9: s6 = 6'b100101; 5'd10: s6 = 6'b010101; 5'd11: s6 = 6'b110100;
            5'd12: s6 = 6'b001101; 5'd13: s6 = 6'b101100; 5'd14: s6 = 6'b011100; 5'd15: s6 = 6'b010111;
            5'd16: s6 = 6'b011011; 5'd17: s6 = 6'b100011; 5'd18: s6 = 6'b010011; 5'd19: s6 = 6'b110010;
            5'd20: s6 = 6'b001011; 5'd21: s6 = 6'b101010; 5'd22: s6 = 6'b011010; 5'd23: s6 = 6'b111010;
            5'd24: s6 = 6'b110011; 5'd25: s6 = 6'b100110; 5'd26: s6 = 6'b010110; 5'd27: s6 = 6'b110110;
            5'd28: s6 = 6'b001110; 5'd29: s6 = 6'b101110; 5'd30: s6 = 6'b011110; default: s6 = 6'b101011;
         endcase
         if (k && d[4:0] == 5'd28)
            s6 = 6'b001111;
         // Table is RD- form; flip unbalanced or 111000 codes for RD+
         if (r1 && (s6[5]+s6[4]+s6[3]+s6[2]+s6[1]+s6[0] != 3 || s6 == 6'b111000))
            s6 = ~s6;
         if (s6[5]+s6[4]+s6[3]+s6[2]+s6[1]+s6[0] != 3)
            r1 = ~r1;
         alt = (!r1 && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20)) ||
               (r1 && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)) || k;
         case (d[7:5])
            3'd0: s4 = 4'b1011; 3'd1: s4 = 4'b1001; 3'd2: s4 = 4'b0101; 3'd3: s4 = 4'b1100;
            3'd4: s4 = 4'b1101; 3'd5: s4 = 4'b1010; 3'd6: s4 = 4'b0110; default: s4 = alt ? 4'b0111 : 4'b1110;
         endcase
         // Only the negative-disparity side of these control codes differs from the data table
         if (k && !r1 && (d[7:5] == 3'd1 || d[7:5] == 3'd2 || d[7:5] == 3'd5 || d[7:5] == 3'd6))
            s4 = ~s4;
         if (r1 && (s4[3]+s4[2]+s4[1]+s4[0] != 2 || s4 == 4'b1100))
            s4 = ~s4;
         if (s4[3]+s4[2]+s4[1]+s4[0] != 2)
            r1 = ~r1;
         enc8b10b = {r1, s6, s4};
      end
   endfunction
   // ****************************************
   // Scrambler, one octet, msb first
   // ****************************************
   function [22:0] scr8; // {state[14:0], out[7:0]}
      input [14:0] st;
      input [7:0] d;
      integer j;
      reg [14:0] s;
      reg [7:0] o;
      reg b;
      begin
         s = st;
         o = 8'h00;
         for (j = 7; j >= 0; j = j - 1)
         begin
            b = d[j] ^ s[13] ^ s[14];
            o[j] = b;
            s = {s[13:0], b};
         end
         scr8 = {s, o};
      end
   endfunction
   // ****************************************
   // Register bus slave
   // ****************************************
   reg wr_pend_reg;
   reg [11:0] addr_reg;
   reg soft_rst_reg;
   reg divrst_sel_reg;
   reg [31:0] link_cfg_reg;
   reg [15:0] cal_cnt_reg;
   wire addr_ok = i_hsel && i_hready && i_htrans[1];
   wire link_simple = link_cfg_reg[`JLTX_LINK_SIMPLE_BIT];
   wire link_two = link_cfg_reg[`JLTX_LINK_TWO_LANE_BIT] | link_simple;
   wire scr_en = link_cfg_reg[`JLTX_LINK_SCR_EN_BIT];
   wire lanesync = link_cfg_reg[`JLTX_LINK_LANESYNC_BIT];
   wire [3:0] res_m1 = link_cfg_reg[`JLTX_LINK_RES_LSB +: 4]; // [R22]
   wire [4:0] k_m1 = link_cfg_reg[`JLTX_LINK_K_LSB +: 5];      // [R22]
   reg [1:0] state_reg;
   wire [31:0] status_w = {28'h0, o_cal_busy, 1'b0, state_reg};
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 12'h000;
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         soft_rst_reg <= 1'b0;
         divrst_sel_reg <= 1'b0; // [R02]
         link_cfg_reg <= `JLTX_LINK_CFG_RST; // [R06]
         cal_cnt_reg <= 16'h0000;
         o_cal_busy <= 1'b1;
      end
      else
      begin
         wr_pend_reg <= addr_ok && i_hwrite;
         if (addr_ok)
            addr_reg <= i_haddr[11:0];
         // Decode in the address phase so read data stands for the whole data phase
         if (addr_ok && !i_hwrite)
         begin
            case (i_haddr[11:0])
               `JLTX_ADDR_PORT_CFG: o_hrdata <= {26'h0, soft_rst_reg, 5'h0};
               `JLTX_ADDR_SYNC_CFG: o_hrdata <= {31'h0, divrst_sel_reg};
               `JLTX_ADDR_LINK_CFG: o_hrdata <= link_cfg_reg;
               `JLTX_ADDR_STATUS: o_hrdata <= status_w;
               default: o_hrdata <= 32'h0000_0000;
            endcase
         end
         // Calibration counter; a fresh soft reset restarts it
         if (wr_pend_reg && addr_reg == `JLTX_ADDR_PORT_CFG && i_hwdata[`JLTX_PORT_SOFT_RST_BIT])
         begin
            soft_rst_reg <= 1'b1; // [R04]
            cal_cnt_reg <= 16'h0000;
            o_cal_busy <= 1'b1;
         end
         else if (o_cal_busy)
         begin
            if (cal_cnt_reg == CAL_CYCLES[15:0] - 16'h0001)
            begin
               o_cal_busy <= 1'b0;
               soft_rst_reg <= 1'b0; // [R05]
            end
            else
               cal_cnt_reg <= cal_cnt_reg + 16'h0001;
         end
         if (wr_pend_reg && addr_reg == `JLTX_ADDR_SYNC_CFG)
            divrst_sel_reg <= i_hwdata[`JLTX_SYNC_DIVRST_BIT]; // [R01]
         if (wr_pend_reg && addr_reg == `JLTX_ADDR_LINK_CFG)
            link_cfg_reg <= i_hwdata; // [R09]
      end
   end
   // ****************************************
   // Link layer
   // ****************************************
   reg sync_q_reg;
   reg [1:0] mf_reg;
   reg [4:0] fr_reg;
   reg [2:0] oct_reg;
   reg [14:0] scr_reg [0:2];
   reg [2:0] rd_reg;
   reg [7:0] last_reg [0:2];
   reg [13:0] hold_reg [0:5]; // Sample hold across a frame
   reg [2:0] samp_cnt_reg;
   // Sync routed to link only when not used as divider reset
   wire link_sync_b = divrst_sel_reg ? 1'b1 : i_sync_b; // [R01] [R20]
   wire release_ev = !sync_q_reg && link_sync_b;          // [R19]
   wire [2:0] f_m1 = link_simple ? 3'd1 : 3'd6;
   wire frame_end = oct_reg == f_m1;
   wire mf_end = frame_end && fr_reg == k_m1;
   // Reduced resolution zeroes low bits (N kept, information dropped)
   wire [13:0] mask = ~((14'h3fff >> (res_m1 + 4'h1)) & 14'h3fff) | 14'h0000;
   wire [13:0] sa = i_samp_a & mask;
   wire [13:0] sb = i_samp_b & mask;
   reg [7:0] oct_w [0:2];
   reg [1:0] ctl_w;
   reg [167:0] blk;
   integer ln;
   integer ci;
   always @*
   begin
      // Padded to three full lane slices so no lane reads past the block
      blk = {hold_reg[0], hold_reg[1], hold_reg[2], hold_reg[3], hold_reg[4], hold_reg[5], 84'h0};
      ctl_w = 2'b00;
      for (ci = 0; ci < 3; ci = ci + 1)
      begin
         oct_w[ci] = 8'h00;
         if (state_reg == ST_CGS)
            oct_w[ci] = `JLTX_K28_5; // [R10] [R23]
         else if (state_reg == ST_ILA)
         begin
            if (oct_reg == 3'd0 && fr_reg == 5'd0)
               oct_w[ci] = `JLTX_K28_0; // [R12]
            else if (mf_end)
               oct_w[ci] = `JLTX_K28_3;
            else if (mf_reg == 2'd1 && fr_reg == 5'd0 && oct_reg == 3'd1)
               oct_w[ci] = `JLTX_K28_4;
            else if (mf_reg == 2'd1 && fr_reg == 5'd0)
               oct_w[ci] = {link_simple, link_two, k_m1, ci[0]}; // [R13]
            else
               oct_w[ci] = {5'h0, oct_reg};
         end
         else if (link_simple)
            // 14-bit sample plus two zero tail bits per lane [R07]
            oct_w[ci] = oct_reg[0] ? {(ci == 0 ? i_samp_a[5:0] & mask[5:0] : sb[5:0]), 2'b00}
                                   : (ci == 0 ? sa[13:6] : sb[13:6]);
         else
            // 56-bit lane slice of the concatenated frame block [R08]
            oct_w[ci] = blk[167 - 8 * (ci * 7 + oct_reg) -: 8];
      end
   end
   always @(posedge i_clk)
   begin
      if (!i_rst_b || o_cal_busy)
      begin
         sync_q_reg <= 1'b0;
         state_reg <= ST_CGS;
         mf_reg <= 2'd0;
         fr_reg <= 5'd0;
         oct_reg <= 3'd0;
         rd_reg <= 3'b000;
         samp_cnt_reg <= 3'd0;
         o_lane_sym <= 30'h0000_0000;
         o_lane_en <= 3'b000;
         o_div_rst <= 1'b0;
         for (ln = 0; ln < 3; ln = ln + 1)
         begin
            scr_reg[ln] <= 15'h0000;
            last_reg[ln] <= 8'h00;
         end
         for (ln = 0; ln < 6; ln = ln + 1)
            hold_reg[ln] <= 14'h0000;
      end
      else
      begin
         sync_q_reg <= link_sync_b;
         o_div_rst <= divrst_sel_reg && !i_sync_b;
         o_lane_en <= link_two ? 3'b011 : 3'b111;
         if (!link_sync_b)
         begin
            state_reg <= ST_CGS; // [R10]
            oct_reg <= 3'd0;
            fr_reg <= 5'd0;
            mf_reg <= 2'd0;
         end
         else
         begin
            // Counters stay at zero on the release edge so the sequence opens at octet 0
            if (release_ev)
               state_reg <= ST_ILA; // [R12]
            else
            begin
               oct_reg <= frame_end ? 3'd0 : oct_reg + 3'd1;
               if (frame_end)
                  fr_reg <= (fr_reg == k_m1) ? 5'd0 : fr_reg + 5'd1;
               if (mf_end)
                  mf_reg <= mf_reg + 2'd1;
               if (state_reg == ST_ILA && mf_end && mf_reg == `JLTX_ILA_MF)
                  state_reg <= ST_DATA; // [R14]
            end
         end
         // Efficient mode: gather samples into the frame block
         if (!link_simple && link_sync_b)
         begin
            samp_cnt_reg <= frame_end ? 3'd0 : samp_cnt_reg + 3'd1;
            if (samp_cnt_reg < 3'd3)
            begin
               hold_reg[samp_cnt_reg] <= sa;
               hold_reg[samp_cnt_reg + 3'd3] <= sb;
            end
         end
         for (ln = 0; ln < 3; ln = ln + 1)
         begin : lane
            reg [22:0] sc;
            reg [7:0] d;
            reg kf;
            reg [10:0] e;
            sc = scr8(scr_reg[ln], oct_w[ln]);
            d = oct_w[ln];
            kf = state_reg != ST_DATA && (d == `JLTX_K28_5 || d == `JLTX_K28_0 ||
                                          d == `JLTX_K28_3 || d == `JLTX_K28_4);
            if (state_reg == ST_DATA)
            begin
               if (scr_en)
                  d = sc[7:0]; // [R17]
               if (frame_end)
                  last_reg[ln] <= d;
               if (frame_end && d == last_reg[ln])
               begin
                  kf = 1'b1;
                  if (mf_end && lanesync)
                     d = `JLTX_K28_3; // [R16]
                  else
                     d = `JLTX_K28_7; // [R15]
               end
            end
            if (state_reg != ST_CGS)
               scr_reg[ln] <= sc[22:8]; // [R18]
            e = enc8b10b(d, kf, rd_reg[ln]); // [R21]
            rd_reg[ln] <= e[10];
            o_lane_sym[10 * ln +: 10] <= e[9:0];
         end
      end
   end
endmodule // jltx_top

// file: verification/jltx_sva.sv
`timescale 1ns/100ps
module jltx_sva
#(
   parameter int CAL_CYCLES = 20
)
(
   input logic i_clk, // Sample clock
   input logic i_rst_b, // Reset, active low
   input logic i_sync_b, // Sync pin level
   input logic o_hreadyout, // Bus ready
   input logic o_hresp, // Bus response
   input logic [29:0] o_lane_sym, // Lane symbols
   input logic [2:0] o_lane_en, // Active lanes
   input logic o_div_rst, // Divider reset
   input logic o_cal_busy // Calibration running
);
   localparam int CAL_MAX = CAL_CYCLES + 2;
   logic [7:0] busy_cnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   function automatic logic kis(input logic [9:0] s, input logic [3:0] f);
      return s == {6'h0f, f} || s == {6'h30, ~f};
   endfunction
   // Length of the running calibration, so a stuck one is caught
   always @(posedge i_clk)
      busy_cnt <= (!i_rst_b || !o_cal_busy) ? 8'h00 : busy_cnt + 8'h01;
   sequence s_cgs;
      !$past(i_sync_b) && !$past(i_sync_b, 2) && !o_div_rst && !o_cal_busy && !$past(o_cal_busy);
   endsequence
   sequence s_commas;
      (!o_lane_en[0] || kis(o_lane_sym[9:0], 4'ha)) && (!o_lane_en[1] || kis(o_lane_sym[19:10], 4'ha))
         && (!o_lane_en[2] || kis(o_lane_sym[29:20], 4'ha));
   endsequence
   sequence s_release;
      !$past(i_sync_b) && i_sync_b && !o_div_rst && !o_cal_busy;
   endsequence
   a_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus not ready or not okay");
   a_div_cause: assert property (o_div_rst |-> !$past(i_sync_b))
      else $error("divider reset without low sync");
   a_div_release: assert property (o_div_rst && i_sync_b |=> !o_div_rst)
      else $error("divider reset outlives sync");
   a_div_default: assert property (!$past(i_rst_b) |-> !o_div_rst [*2])
      else $error("divider reset active after reset");
   a_comma_sync: assert property (s_cgs |-> s_commas)
      else $error("no comma while sync asserted");
   a_ila_start: assert property (s_release |-> ##[1:2] kis(o_lane_sym[9:0], 4'h4))
      else $error("alignment start missing after release");
   a_cal_bound: assert property (busy_cnt <= CAL_MAX)
      else $error("calibration runs too long");
   a_lanes_quiet: assert property (o_cal_busy && $past(o_cal_busy) |-> o_lane_sym == 30'h0)
      else $error("lanes active during calibration");
endmodule // jltx_sva
bind jltx_top jltx_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_sync_b(i_sync_b), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_lane_sym(o_lane_sym),
   .o_lane_en(o_lane_en), .o_div_rst(o_div_rst), .o_cal_busy(o_cal_busy));

// file: verification/jltx_rx_model.sv
`timescale 1ns/100ps
module jltx_rx_model
(
   input logic i_clk, // Sample clock
   input logic i_rst_b, // Reset, active low
   input logic i_start, // Begin link start-up
   input logic i_abort, // Release sync without alignment
   input logic i_slow, // Demand a long comma run
   input logic [29:0] i_lane_sym, // Lane symbols
   input logic [2:0] i_lane_en, // Active lanes
   output logic o_sync_b // Sync request, low = asserted
);
   logic [4:0] run_reg;
   logic [2:0] comma;
   for (genvar n = 0; n < 3; n++)
   begin : g_k
      assign comma[n] = i_lane_sym[10*n+9:10*n] == 10'h0fa || i_lane_sym[10*n+9:10*n] == 10'h305;
   end
   // Sync changes only on the sample clock so the release edge is well timed
   always @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_sync_b <= 1'b1;
         run_reg <= 5'h00;
      end
      else if (i_start)
      begin
         o_sync_b <= 1'b0;
         run_reg <= 5'h00;
      end
      else if (!o_sync_b)
      begin
         run_reg <= &(comma | ~i_lane_en) ? run_reg + 5'h01 : 5'h00;
         if (i_abort || run_reg == (i_slow ? 5'h0f : 5'h03))
            o_sync_b <= 1'b1;
      end
   end
endmodule // jltx_rx_model

// file: verification/jltx_top_tb.sv
`timescale 1ns/100ps
`include "jltx_regs.vh"
module jltx_top_tb;
   localparam int CAL = 4;
   logic clk, rst_b, hsel, hwrite, start, abort, slow, rdy, resp, sync_b, div_rst, busy;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [29:0] sym;
   logic [2:0] lane_en;
   int n_fail, checked;
   // ****************
   // Clock and instances
   // ****************
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   jltx_top #(.CAL_CYCLES(CAL)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(rdy),
      .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp), .i_sync_b(sync_b), .i_samp_a(14'h1555),
      .i_samp_b(14'h0aaa), .o_lane_sym(sym), .o_lane_en(lane_en), .o_div_rst(div_rst), .o_cal_busy(busy));
   jltx_rx_model u_rx (.i_clk(clk), .i_rst_b(rst_b), .i_start(start), .i_abort(abort), .i_slow(slow),
      .i_lane_sym(sym), .i_lane_en(lane_en), .o_sync_b(sync_b));
   // ****************
   // Shared tasks
   // ****************
   function automatic logic kis(input logic [9:0] s, input logic [3:0] f);
      return s === {6'h0f, f} || s === {6'h30, ~f};
   endfunction
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      for (int p = 0; p < 2; p++)
      begin
         n = 0;
         @(posedge clk);
         while (rdy !== 1'b1 && n < 50)
         begin
            n++;
            @(posedge clk);
         end
         if (n >= 50)
            n_fail++;
         if (p == 0)
         begin
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
         end
      end
      rd = hrdata;
   endtask
   task pulse(input int which);
      if (which == 0) start <= 1'b1; else abort <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      abort <= 1'b0;
   endtask
   // ****************
   // Scenarios
   // ****************
   task t_regs;
      ahb(1'b0, `JLTX_ADDR_LINK_CFG, 32'h0);
      chk("link cfg", `JLTX_LINK_CFG_RST, rd);
      ahb(1'b0, `JLTX_ADDR_SYNC_CFG, 32'h0);
      chk("sync cfg", `JLTX_SYNC_CFG_RST, rd);
      ahb(1'b1, 12'h200, 32'hffff_ffff);
      ahb(1'b0, 12'h200, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask
   // Runs start-up to data; fl is the frame length in octets
   task t_link(input int fl, input logic [2:0] en, input logic s);
      int i, n0, n3, n7;
      slow <= s;
      pulse(0);
      i = 0;
      do
      begin
         @(negedge clk);
         i++;
      end while (!kis(sym[9:0], 4'h4) && i < 300);
      chk("lanes", {29'h0, en}, {29'h0, lane_en});
      n0 = 0;
      n3 = 0;
      n7 = 0;
      for (i = 0; i < 56 * fl; i++)
      begin
         n0 += kis(sym[9:0], 4'h4);
         n3 += kis(sym[9:0], 4'h3);
         if (i == 14 * fl + 1) chk("mf2 marker", 32'h1, {31'h0, kis(sym[9:0], 4'h2)});
         @(negedge clk);
      end
      chk("ila starts", 32'h4, 32'(n0));
      chk("ila ends", 32'h4, 32'(n3));
      ahb(1'b0, `JLTX_ADDR_STATUS, 32'h0);
      chk("state", 32'h2, {30'h0, rd[1:0]});
      n3 = 0;
      for (i = 0; i < 28 * fl; i++)
      begin
         @(negedge clk);
         n3 += kis(sym[9:0], 4'h3);
         n7 += kis(sym[9:0], 4'h8);
      end
      chk("frame subst", 32'h1, {31'h0, n7 > 0});
      chk("mf subst", 32'h1, {31'h0, n3 > 0});
   endtask
   task t_div;
      ahb(1'b1, `JLTX_ADDR_SYNC_CFG, 32'h1);
      ahb(1'b0, `JLTX_ADDR_SYNC_CFG, 32'h0);
      chk("sync cfg", 32'h1, rd);
      pulse(0);
      repeat (4) @(negedge clk);
      chk("div reset", 32'h1, {31'h0, div_rst});
      chk("comma", 32'h0, {31'h0, kis(sym[9:0], 4'ha)});
      @(posedge clk);
      pulse(1);
      repeat (3) @(negedge clk);
      chk("div reset off", 32'h0, {31'h0, div_rst});
      @(posedge clk);
      ahb(1'b1, `JLTX_ADDR_SYNC_CFG, 32'h0);
   endtask
   task t_soft;
      int i;
      ahb(1'b1, `JLTX_ADDR_PORT_CFG, 32'h20);
      i = 0;
      while (busy !== 1'b1 && i < 5)
      begin
         @(negedge clk);
         i++;
      end
      chk("cal started", 32'h1, {31'h0, busy});
      while (busy !== 1'b0 && i < 60)
      begin
         @(negedge clk);
         i++;
      end
      @(posedge clk);
      ahb(1'b0, `JLTX_ADDR_PORT_CFG, 32'h0);
      chk("soft bit", 32'h0, {31'h0, rd[5]});
   endtask
   task end_sim;
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****************
   // Main sequence and watchdog
   // ****************
   initial
   begin
      {rst_b, hsel, hwrite, start, abort, slow, htrans, haddr, hwdata} = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (CAL + 4) @(posedge clk);
      t_regs();
      t_link(7, 3'h7, 1'b0);
      ahb(1'b1, `JLTX_ADDR_LINK_CFG, 32'h0000_0d0b);
      ahb(1'b0, `JLTX_ADDR_LINK_CFG, 32'h0);
      chk("simple cfg", 32'h0000_0d0b, rd);
      t_link(2, 3'h3, 1'b1);
      t_div();
      t_soft();
      end_sim();
   end
   // Normal run is under a thousand cycles
   initial
   begin
      #(20000 * 50);
      n_fail++;
      end_sim();
   end
endmodule // jltx_top_tb
